//--- core/adcs_ctrl.sv
// Purpose: event, sleep and sync control around a converter
// Assumes: APB slave, one clock, converter rate is a tick
// Notes: sample bus and sleep pin are resynchronised
`timescale 1ns/1ns
`include "adcs_defs.svh"
module adcs_ctrl
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // apb slave
    input wire logic [`ADCS_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event router
    input wire adcs_pkg::adcs_evin_s evIn,
    output logic resultReadyEvent,
    output logic windowMatchEvent,
    // analog side
    input wire logic [`ADCS_DW-1:0] convSample,
    output logic analogPowerDown,
    // power manager and cpu
    input wire logic standbySleep,
    output logic irq,
    output logic wakeReq
);
    import adcs_pkg::*;

    // bus decode
    logic access;
    logic ctrlHit;
    logic stall;
    logic done;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] rdMux;
    // software visible state
    logic runStandby_reg;
    logic [3:0] evctl_reg;
    logic [2:0] mask_reg;
    logic [2:0] intStat_reg;
    logic [2:0] rdSnap_reg; // bits handed out by the read
    logic [`ADCS_DW-1:0] winLo_reg;
    logic [`ADCS_DW-1:0] winHi_reg;
    logic [`ADCS_DW-1:0] result_reg;
    // sync path
    logic sync_in_progress_reg;
    logic [1:0] pendCtrl_reg;
    logic [1:0] syncCnt_reg;
    logic syncDone;
    logic enable_reg; // converter side enable
    logic soft_reset_request;
    // converter side
    logic [1:0] div_reg;
    logic tick;
    adcs_state_e state_reg;
    logic [9:0] cnt_reg;
    logic convDone_reg;
    logic winHit;
    logic [`ADCS_DW-1:0] sampA_reg;
    logic [`ADCS_DW-1:0] sampB_reg;
    logic sleepA_reg;
    logic sleepB_reg;
    logic halt;
    logic swStart;
    logic swFlush;
    logic startReq;
    logic flushReq;

    // inclusive window compare
    function automatic logic inWindow(
        input logic [`ADCS_DW-1:0] v,
        input logic [`ADCS_DW-1:0] lo,
        input logic [`ADCS_DW-1:0] hi);
        inWindow = (v >= lo) && (v <= hi);
    endfunction

    // request decode; answer is one wait state late
    assign access = psel & penable;
    assign ctrlHit = (paddr == `ADCS_A_CTRL);
    // holding off a second control write while busy
    assign stall = pwrite & ctrlHit & sync_in_progress_reg;
    assign done = access & pready;
    assign wr = done & pwrite;
    assign rd = done & ~pwrite;
    assign swStart = wr && (paddr == `ADCS_A_TRIG) && pwdata[0];
    assign swFlush = wr && (paddr == `ADCS_A_TRIG) && pwdata[1];
    assign soft_reset_request = syncDone & pendCtrl_reg[`ADCS_B_SOFT_RESET_REQUEST];

    // read mux, unmapped addresses flag an error
    always_comb
    begin
        rdMux = 32'h0;
        mapped = 1'b1;
        case (paddr)
            `ADCS_A_CTRL:
            begin
                rdMux[`ADCS_B_EN] = enable_reg;
                rdMux[`ADCS_B_RSTBY] = runStandby_reg;
            end
            `ADCS_A_EVCTL: rdMux[3:0] = evctl_reg;
            `ADCS_A_MASK: rdMux[2:0] = mask_reg;
            `ADCS_A_INT: rdMux[2:0] = intStat_reg;
            `ADCS_A_STAT:
            begin
                rdMux[`ADCS_S_SB] = sync_in_progress_reg;
                rdMux[`ADCS_S_CB] = (state_reg == ST_CONV);
                rdMux[`ADCS_S_SU] = (state_reg == ST_STARTUP);
                rdMux[`ADCS_S_PD] = analogPowerDown;
            end
            `ADCS_A_TRIG: rdMux = 32'h0; // write only
            `ADCS_A_WLO: rdMux[`ADCS_DW-1:0] = winLo_reg;
            `ADCS_A_WHI: rdMux[`ADCS_DW-1:0] = winHi_reg;
            `ADCS_A_RES: rdMux[`ADCS_DW-1:0] = result_reg;
            default: mapped = 1'b0;
        endcase
    end

    // apb handshake, data captured when pready rises
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            rdSnap_reg <= 3'h0;
        end
        else if (pready)
        begin
            pready <= 1'b0;
        end
        else if (access && !stall)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0 : rdMux;
            pslverr <= ~mapped;
            rdSnap_reg <= (paddr == `ADCS_A_INT && !pwrite) ?
                intStat_reg : 3'h0;
        end
    end

    // plain configuration registers, cleared by soft reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            runStandby_reg <= 1'b0;
            evctl_reg <= 4'h0;
            mask_reg <= 3'h0;
            winLo_reg <= '0;
            winHi_reg <= '0;
        end
        else if (soft_reset_request)
        begin
            runStandby_reg <= 1'b0;
            evctl_reg <= 4'h0;
            mask_reg <= 3'h0;
            winLo_reg <= '0;
            winHi_reg <= '0;
        end
        else if (wr)
        begin
            case (paddr)
                `ADCS_A_CTRL:
                    runStandby_reg <= pwdata[`ADCS_B_RSTBY];
                `ADCS_A_EVCTL: evctl_reg <= pwdata[3:0];
                `ADCS_A_MASK: mask_reg <= pwdata[2:0];
                `ADCS_A_WLO: winLo_reg <= pwdata[`ADCS_DW-1:0];
                `ADCS_A_WHI: winHi_reg <= pwdata[`ADCS_DW-1:0];
                default: ;
            endcase
        end
    end

    // converter rate divider
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    assign tick = (div_reg == `ADCS_DIV_MAX);

    // sync of soft reset and enable into converter rate
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_in_progress_reg <= 1'b0;
            pendCtrl_reg <= 2'h0;
            syncCnt_reg <= 2'h0;
            enable_reg <= 1'b0;
            syncDone <= 1'b0;
        end
        else
        begin
            syncDone <= 1'b0;
            if (wr && ctrlHit)
            begin
                // busy rises on the very write
                sync_in_progress_reg <= 1'b1;
                pendCtrl_reg <= pwdata[1:0];
                syncCnt_reg <= 2'h0;
            end
            else if (sync_in_progress_reg && tick)
            begin
                if (syncCnt_reg == `ADCS_SYNC_TICKS - 2'h1)
                begin
                    sync_in_progress_reg <= 1'b0;
                    syncDone <= 1'b1;
                    // soft reset wins and leaves it off
                    enable_reg <= pendCtrl_reg[`ADCS_B_EN] &
                        ~pendCtrl_reg[`ADCS_B_SOFT_RESET_REQUEST];
                end
                else
                    syncCnt_reg <= syncCnt_reg + 2'h1;
            end
        end
    end

    // pin resynchronisers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sleepA_reg <= 1'b0;
            sleepB_reg <= 1'b0;
            sampA_reg <= '0;
            sampB_reg <= '0;
        end
        else
        begin
            sleepA_reg <= standbySleep;
            sleepB_reg <= sleepA_reg;
            sampA_reg <= convSample;
            sampB_reg <= sampA_reg;
        end
    end

    // halted only in standby without run enable
    assign halt = sleepB_reg & ~runStandby_reg;
    // any channel fires the action
    assign startReq = ((|evIn.start) & evctl_reg[`ADCS_B_STEI]) |
        (swStart & ~sleepB_reg);
    assign flushReq = ((|evIn.flush) & evctl_reg[`ADCS_B_FLEI]) |
        swFlush;
    assign winHit = inWindow(sampB_reg, winLo_reg, winHi_reg);

    // conversion sequencer
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_OFF;
            cnt_reg <= 10'h0;
            convDone_reg <= 1'b0;
        end
        else
        begin
            convDone_reg <= 1'b0;
            if (!enable_reg || halt)
                state_reg <= ST_OFF;
            else
            begin
                case (state_reg)
                    ST_OFF:
                    begin
                        // analog needs settling after power up
                        state_reg <= ST_STARTUP;
                        cnt_reg <= 10'h0;
                    end
                    ST_STARTUP:
                    begin
                        if (cnt_reg == 10'(`ADCS_STARTUP_CYC - 1))
                            state_reg <= ST_IDLE;
                        else
                            cnt_reg <= cnt_reg + 10'h1;
                    end
                    ST_IDLE:
                    begin
                        if (startReq)
                        begin
                            state_reg <= ST_CONV;
                            cnt_reg <= 10'h0;
                        end
                    end
                    ST_CONV:
                    begin
                        if (flushReq)
                            state_reg <= ST_IDLE;
                        else if (startReq)
                            cnt_reg <= 10'h0; // restart
                        else if (tick)
                        begin
                            if (cnt_reg == `ADCS_CONV_TICKS - 10'h1)
                            begin
                                state_reg <= ST_IDLE;
                                convDone_reg <= 1'b1;
                            end
                            else
                                cnt_reg <= cnt_reg + 10'h1;
                        end
                    end
                    default: state_reg <= ST_OFF;
                endcase
            end
        end
    end

    // result and gated output event pulses
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            result_reg <= '0;
            resultReadyEvent <= 1'b0;
            windowMatchEvent <= 1'b0;
        end
        else
        begin
            if (convDone_reg)
                result_reg <= sampB_reg;
            resultReadyEvent <= convDone_reg &
                evctl_reg[`ADCS_B_RREO];
            windowMatchEvent <= convDone_reg & winHit &
                evctl_reg[`ADCS_B_WMEO];
        end
    end

    // sticky flags; new event beats the read clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            intStat_reg <= 3'h0;
        else if (soft_reset_request)
            intStat_reg <= {1'b1, 2'h0};
        else
        begin
            intStat_reg <= (intStat_reg & ~(rd ? rdSnap_reg : 3'h0))
                | {syncDone, convDone_reg & winHit, convDone_reg};
        end
    end

    // interrupt, wake and power outputs
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq <= 1'b0;
            wakeReq <= 1'b0;
            analogPowerDown <= 1'b1;
        end
        else
        begin
            irq <= |(intStat_reg & mask_reg);
            wakeReq <= sleepB_reg & runStandby_reg &
                (|(intStat_reg & mask_reg));
            analogPowerDown <= ~enable_reg | halt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_rr;
        convDone_reg && evctl_reg[`ADCS_B_RREO] |=> resultReadyEvent;
    endproperty
    a_rr: assert property (p_rr) else $error("no ready event");
    property p_gate;
        resultReadyEvent |-> $past(evctl_reg[`ADCS_B_RREO]);
    endproperty
    a_gate: assert property (p_gate) else $error("ungated");
    property p_wm;
        windowMatchEvent |-> $past(convDone_reg && winHit);
    endproperty
    a_wm: assert property (p_wm) else $error("bad window");
    property p_start;
        state_reg == ST_IDLE && enable_reg && !halt &&
        (|evIn.start) && evctl_reg[`ADCS_B_STEI]
        |=> state_reg == ST_CONV;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_flush;
        state_reg == ST_CONV && enable_reg && !halt && flushReq
        |=> state_reg == ST_IDLE && !convDone_reg;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush");
    property p_ign;
        state_reg == ST_IDLE && !evctl_reg[`ADCS_B_STEI] && !swStart
        |=> state_reg != ST_CONV;
    endproperty
    a_ign: assert property (p_ign) else $error("ignored start");
    property p_halt;
        halt |=> state_reg == ST_OFF && analogPowerDown;
    endproperty
    a_halt: assert property (p_halt) else $error("not halted");
    property p_su;
        $past(state_reg) == ST_OFF && state_reg != ST_OFF
        |-> state_reg == ST_STARTUP;
    endproperty
    a_su: assert property (p_su) else $error("skipped startup");
    property p_busy;
        wr && ctrlHit |=> sync_in_progress_reg ##[1:12] !sync_in_progress_reg;
    endproperty
    a_busy: assert property (p_busy) else $error("sync busy");
    property p_srdy;
        $fell(sync_in_progress_reg) |=> intStat_reg[`ADCS_I_SR];
    endproperty
    a_srdy: assert property (p_srdy) else $error("no sync rdy");
    property p_stall;
        access && pwrite && ctrlHit && sync_in_progress_reg |=> !pready;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_en;
        $changed(enable_reg) |-> $past(sync_in_progress_reg);
    endproperty
    a_en: assert property (p_en) else $error("unsynced en");
    property p_pulse;
        resultReadyEvent |=> !resultReadyEvent;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long evt");

    c_conv: cover property (convDone_reg ##1 resultReadyEvent);
    c_stall: cover property (stall ##[1:12] pready);
    c_wake: cover property (wakeReq);
endmodule // adcs_ctrl

//--- core/adcs_defs.svh
// Purpose: constants of the converter control block
// Assumes: byte addresses on an 8-bit APB address
// Notes: startup count derives from the clock period
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// widths
`define ADCS_DW 12
`define ADCS_NCH 4
`define ADCS_AW 8
// register byte addresses
`define ADCS_A_CTRL 8'h00
`define ADCS_A_EVCTL 8'h04
`define ADCS_A_MASK 8'h08
`define ADCS_A_INT 8'h0c
`define ADCS_A_STAT 8'h10
`define ADCS_A_TRIG 8'h14
`define ADCS_A_WLO 8'h18
`define ADCS_A_WHI 8'h1c
`define ADCS_A_RES 8'h20
// control_primary bits
`define ADCS_B_SOFT_RESET_REQUEST 0
`define ADCS_B_EN 1
`define ADCS_B_RSTBY 2
// event_control bits
`define ADCS_B_STEI 0
`define ADCS_B_FLEI 1
`define ADCS_B_RREO 2
`define ADCS_B_WMEO 3
// interrupt bits
`define ADCS_I_RR 0
`define ADCS_I_WM 1
`define ADCS_I_SR 2
// status bits
`define ADCS_S_SB 0
`define ADCS_S_CB 1
`define ADCS_S_SU 2
`define ADCS_S_PD 3
// timing
`define ADCS_DIV_MAX 2'h3
`define ADCS_SYNC_TICKS 2'h2
`define ADCS_CONV_TICKS 10'h00d
`define ADCS_CLK_NS 20
`define ADCS_STARTUP_NS 20000
`define ADCS_STARTUP_CYC \
    ((`ADCS_STARTUP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`endif

//--- core/adcs_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: constants come from adcs_defs.svh
// Notes: none
`include "adcs_defs.svh"
package adcs_pkg;
    // converter sequencer states
    typedef enum logic [1:0] {ST_OFF, ST_STARTUP, ST_IDLE, ST_CONV}
        adcs_state_e;
    // incoming event channels from the router
    typedef struct packed {
        logic [`ADCS_NCH-1:0] start;
        logic [`ADCS_NCH-1:0] flush;
    } adcs_evin_s;
endpackage

//--- dv/adcs_router.sv
// Purpose: event router model feeding the converter control block
// Assumes: events are one-cycle pulses on mclk
// Notes: the sample pin is a driven level, so it simply holds
`timescale 1ns/1ns
`include "adcs_defs.svh"
module adcs_router
(
    // clock
    input wire logic mclk,
    // event channels and analog pin
    output adcs_pkg::adcs_evin_s evIn,
    output logic [`ADCS_DW-1:0] convSample
);
    import adcs_pkg::*;
    // quiet channels at time zero
    initial
    begin
        evIn = '0;
        convSample = 12'h000;
    end
    // one pulse on any channel, so every route can be tried
    task automatic fire(input logic isFlush, input logic [1:0] ch);
        @(posedge mclk);
        if (isFlush)
            evIn.flush[ch] <= 1'b1;
        else
            evIn.start[ch] <= 1'b1;
        @(posedge mclk);
        evIn <= '0;
    endtask
    // new analog level, changed just after an edge
    task automatic setSample(input logic [`ADCS_DW-1:0] v);
        convSample <= v;
    endtask
endmodule // adcs_router

//--- dv/tb.sv
// Purpose: self-checking bench of the converter control block
// Assumes: APB master tasks, events from the router model
// Notes: startup delay is not shortened, so waits are long
`timescale 1ns/1ns
`include "adcs_defs.svh"
module tb;
    import adcs_pkg::*;
    logic mclk;
    logic arst_n;
    logic [7:0] paddr;
    logic psel, penable, pwrite;
    logic [31:0] pwdata, prdata, rdq;
    logic pready, pslverr, rdErr;
    adcs_evin_s evIn;
    logic resultReadyEvent, windowMatchEvent;
    logic [11:0] convSample;
    logic analogPowerDown, standbySleep, irq, wakeReq;
    logic rrPrev, wmPrev;
    int nErrors, comparisons, lastN, rrCnt, wmCnt, longCnt, cyc;
    adcs_ctrl adcs_ctrl_i (.mclk(mclk), .arst_n(arst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evIn(evIn),
        .resultReadyEvent(resultReadyEvent),
        .windowMatchEvent(windowMatchEvent), .convSample(convSample),
        .analogPowerDown(analogPowerDown), .standbySleep(standbySleep),
        .irq(irq), .wakeReq(wakeReq));
    adcs_router adcs_router_i (.mclk(mclk), .evIn(evIn),
        .convSample(convSample));
    // free-running clock, 20 ns period
    always #10 mclk = ~mclk;
    // verdict and end of run, reached from the hang guard or the main sequence
    task automatic stop_test();
        $display("counts: %0d errors, %0d comparisons", nErrors, comparisons);
        if (nErrors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles needed
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            nErrors++;
            stop_test();
        end
    end
    // count event pulses; a pulse two cycles long is a fault
    always @(posedge mclk)
    begin
        if (resultReadyEvent === 1'b1)
            rrCnt++;
        if (windowMatchEvent === 1'b1)
            wmCnt++;
        if ((resultReadyEvent & rrPrev) === 1'b1)
            longCnt++;
        if ((windowMatchEvent & wmPrev) === 1'b1)
            longCnt++;
        rrPrev <= resultReadyEvent;
        wmPrev <= windowMatchEvent;
    end
    // compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        lastN = 0;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            lastN++;
        end
        while (pready !== 1'b1);
        rdq = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle cycle keeps each strobe to one change per step
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // read and compare the masked word
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdq & m, e);
    endtask
    task automatic waitCyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // poll until no sync, startup or conversion is under way
    task automatic waitIdle();
        for (int i = 0; i < 400; i++)
        begin
            apb(1'b0, `ADCS_A_STAT, 32'h0);
            if (rdq[2:0] === 3'h0)
                break;
        end
    endtask
    // one start event, then the pulses that followed it
    task automatic conv(input logic [1:0] ch, input int er, input int ew);
        int r0;
        int w0;
        r0 = rrCnt;
        w0 = wmCnt;
        adcs_router_i.fire(1'b0, ch);
        waitCyc(80);
        waitIdle();
        chk(rrCnt - r0, er);
        chk(wmCnt - w0, ew);
    endtask
    task automatic endTest(input string s);
        $display("test %s done", s);
    endtask
    logic [11:0] smp [4] = '{12'h5a5, 12'h700, 12'h701, 12'h0ff};
    int inWin [4] = '{1, 1, 0, 0};
    // main sequence
    initial
    begin
        mclk = 1'b0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        standbySleep = 1'b0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdc(`ADCS_A_STAT, 32'hffffffff, 32'h8);
        rdc(8'h24, 32'hffffffff, 32'h0);
        chk(rdErr, 1'b1);
        endTest("reset");
        // second enable write lands while the first is in sync
        wr(`ADCS_A_CTRL, 32'h2);
        wr(`ADCS_A_CTRL, 32'h2);
        chk(lastN > 2, 1'b1);
        rdc(`ADCS_A_STAT, 32'h1, 32'h1);
        rdc(`ADCS_A_CTRL, 32'hffffffff, 32'h2);
        waitCyc(20);
        rdc(`ADCS_A_STAT, 32'h1, 32'h0);
        rdc(`ADCS_A_INT, 32'hffffffff, 32'h4);
        waitIdle();
        rdc(`ADCS_A_STAT, 32'hf, 32'h0);
        endTest("sync");
        wr(`ADCS_A_WLO, 32'h100);
        wr(`ADCS_A_WHI, 32'h700);
        adcs_router_i.setSample(12'h5a5);
        wr(`ADCS_A_EVCTL, 32'hc);
        conv(2'd0, 0, 0);
        wr(`ADCS_A_EVCTL, 32'hf);
        for (int i = 0; i < 4; i++)
        begin
            adcs_router_i.setSample(smp[i]);
            conv(i[1:0], 1, inWin[i]);
        end
        rdc(`ADCS_A_RES, 32'hfff, 32'h0ff);
        endTest("events");
        rdc(`ADCS_A_INT, 32'hffffffff, 32'h3);
        chk(irq, 1'b0);
        adcs_router_i.setSample(12'h200);
        wr(`ADCS_A_EVCTL, 32'h3);
        conv(2'd2, 0, 0);
        wr(`ADCS_A_MASK, 32'h1);
        waitCyc(2);
        chk(irq, 1'b1);
        rdc(`ADCS_A_INT, 32'hffffffff, 32'h3);
        waitCyc(2);
        chk(irq, 1'b0);
        endTest("irq");
        wr(`ADCS_A_EVCTL, 32'hf);
        lastN = rrCnt;
        adcs_router_i.fire(1'b0, 2'd0);
        waitCyc(5);
        adcs_router_i.fire(1'b1, 2'd3);
        // give an unflushed conversion time to finish
        waitCyc(80);
        chk(rrCnt - lastN, 0);
        rdc(`ADCS_A_STAT, 32'h2, 32'h0);
        endTest("flush");
        wr(`ADCS_A_CTRL, 32'h6);
        standbySleep <= 1'b1;
        waitCyc(4);
        wr(`ADCS_A_TRIG, 32'h1);
        rdc(`ADCS_A_STAT, 32'h2, 32'h0);
        conv(2'd1, 1, 1);
        waitCyc(2);
        chk(wakeReq, 1'b1);
        rdc(`ADCS_A_INT, 32'h1, 32'h1);
        waitCyc(2);
        chk(wakeReq, 1'b0);
        endTest("standby run");
        wr(`ADCS_A_CTRL, 32'h2);
        waitCyc(20);
        chk(analogPowerDown, 1'b1);
        rdc(`ADCS_A_EVCTL, 32'hf, 32'hf);
        adcs_router_i.fire(1'b0, 2'd0);
        rdc(`ADCS_A_STAT, 32'ha, 32'h8);
        standbySleep <= 1'b0;
        waitCyc(4);
        rdc(`ADCS_A_STAT, 32'h4, 32'h4);
        // starts are refused until the start-up delay has run out
        waitIdle();
        conv(2'd0, 1, 1);
        endTest("standby halt");
        wr(`ADCS_A_CTRL, 32'h1);
        waitCyc(20);
        rdc(`ADCS_A_CTRL, 32'hf, 32'h0);
        rdc(`ADCS_A_EVCTL, 32'hf, 32'h0);
        rdc(`ADCS_A_INT, 32'h4, 32'h4);
        chk(analogPowerDown, 1'b1);
        chk(longCnt, 0);
        endTest("soft reset");
        stop_test();
    end
endmodule // tb
